// File: logic/pupc_top.sv
`timescale 1ns/100ps
// Operation
// - ev selector 8 bits; top bit picks occupancy increment source
// - four 48-bit general counters, software readable and writable
// - overflow is a carry out of counter bit 47
// - after overflow the counter wraps and keeps counting
// - counters are readable while counting continues
// - count sits in bits 47:0, bits 63:48 read zero
// - filter holds four 8-bit band limits, reset zero
// - band limits are frequency ratios in 100 MHz steps
// - all four bands tracked at once, each its own event
// - C3 and C6 counters add one per cycle any core resides
// - C-state counters ignore freeze and general counter controls
// - C-state counters are 64-bit read/write, reset zero
// - three 4-bit core counts for C0, C3, C6 every cycle
// - occupancy select with threshold zero accumulates core count
// - threshold five counts cycles with more than four cores
// - threshold plus edge detect counts entries into that state
// - event code 0x03 counts voltage change cycles
// - occupancy selector 01 C0, 10 C3, 11 C6
// - cycle counts when increment at least threshold; invert gives less for occupancy selections only
// - edge detect with a nonzero threshold counts rising edges, else every asserted cycle
// - overflow with enable sets status bit and sends message
module pupc_top
  import pupc_pkg::*;
#(
  parameter int NUM_CORES = 15,
  // arbitrary value, identifies this unit to the global monitor
  parameter logic [7:0] UNIT_ID = 8'h5a
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic [DATA_W-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [NUM_CORES-1:0] core_in_c0,
  input wire logic [NUM_CORES-1:0] core_in_c3,
  input wire logic [NUM_CORES-1:0] core_in_c6,
  input wire logic [BAND_W-1:0] freq_ratio,
  input wire logic [NUM_EV-1:0] direct_events,
  input wire logic global_freeze,
  output logic ovf_msg_valid,
  output logic [7:0] ovf_msg_unit,
  output logic [NUM_CTR-1:0] ovf_msg_mask
);
  ////////////////////////////////////////////////////////////////////////
  // state
  logic [DATA_W-1:0] ctl_q [NUM_CTR];
  logic [DATA_W-1:0] filter_q;
  logic [NUM_CTR-1:0] status_q;
  logic [NUM_CTR-1:0] status_d;
  logic [CST_W-1:0] c3_q;
  logic [CST_W-1:0] c3_d;
  logic [CST_W-1:0] c6_q;
  logic [CST_W-1:0] c6_d;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [ADDR_W-1:0] addr_q;
  logic addr_ok_q;
  logic [DATA_W-1:0] hrdata_q;
  logic hreadyout_q;
  logic ovf_valid_q;
  logic [NUM_CTR-1:0] ovf_mask_q;
  logic [DATA_W-1:0] rd_mux;
  logic [OCC_W-1:0] occ_c0;
  logic [OCC_W-1:0] occ_c3;
  logic [OCC_W-1:0] occ_c6;
  logic any_c3;
  logic any_c6;
  logic [CTR_W-1:0] ctr_val [NUM_CTR];
  logic [NUM_CTR-1:0] carry_vec;
  logic [NUM_BANDS-1:0] band_hit;

  ////////////////////////////////////////////////////////////////////////
  // bus slave: writes land in the data phase; reads insert one wait
  // state so a read right after a write sees the written value
  wire take = hsel & hready & htrans[1];
  wire wr_now = wr_pend_q & addr_ok_q;
  wire [1:0] ctr_idx = addr_q[4:3];
  wire ctr_hi = addr_q[2];
  wire [1:0] ctl_idx = addr_q[3:2];
  wire in_ctr = addr_q[ADDR_W-1:5] == OFS_CTR_BASE[ADDR_W-1:5];
  wire in_ctl = addr_q[ADDR_W-1:4] == OFS_CTL_BASE[ADDR_W-1:4];
  wire hit_filter = addr_q == OFS_FILTER;
  wire hit_filter_hi = addr_q == OFS_FILTER_HI;
  wire hit_status = addr_q == OFS_STATUS;
  wire hit_c6_lo = addr_q == OFS_C6_LO;
  wire hit_c6_hi = addr_q == OFS_C6_HI;
  wire hit_c3_lo = addr_q == OFS_C3_LO;
  wire hit_c3_hi = addr_q == OFS_C3_HI;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= '0;
      addr_ok_q <= 1'b0;
      hreadyout_q <= 1'b1;
    end else begin
      wr_pend_q <= take & hwrite;
      rd_pend_q <= take & ~hwrite;
      hreadyout_q <= ~(take & ~hwrite);
      if (take) begin
        addr_q <= haddr[ADDR_W-1:0];
        addr_ok_q <= (haddr[31:ADDR_W] == '0) && (haddr[1:0] == 2'h0);
      end
    end
  end

  // unmapped words read zero and ignore writes
  always_comb begin
    rd_mux = '0;
    if (!addr_ok_q) begin
      rd_mux = '0;
    end else if (in_ctr && ctr_hi) begin
      rd_mux = {{(2*DATA_W-CTR_W){1'b0}},
        ctr_val[ctr_idx][CTR_W-1:DATA_W]};
    end else if (in_ctr) begin
      rd_mux = ctr_val[ctr_idx][DATA_W-1:0];
    end else if (in_ctl) begin
      rd_mux = ctl_q[ctl_idx];
    end else if (hit_filter) begin
      rd_mux = filter_q;
    end else if (hit_filter_hi) begin
      rd_mux = '0;
    end else if (hit_status) begin
      rd_mux = {{(DATA_W-NUM_CTR){1'b0}}, status_q};
    end else if (hit_c6_lo) begin
      rd_mux = c6_q[DATA_W-1:0];
    end else if (hit_c6_hi) begin
      rd_mux = c6_q[CST_W-1:DATA_W];
    end else if (hit_c3_lo) begin
      rd_mux = c3_q[DATA_W-1:0];
    end else if (hit_c3_hi) begin
      rd_mux = c3_q[CST_W-1:DATA_W];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= '0;
    end else if (rd_pend_q) begin
      hrdata_q <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // occupancy and band residency sources
  pupc_occupancy #(
    .NUM_CORES(NUM_CORES)
  ) u_occ (
    .hclk(hclk),
    .hresetn(hresetn),
    .core_in_c0(core_in_c0),
    .core_in_c3(core_in_c3),
    .core_in_c6(core_in_c6),
    .occ_c0_q(occ_c0),
    .occ_c3_q(occ_c3),
    .occ_c6_q(occ_c6),
    .any_c3_q(any_c3),
    .any_c6_q(any_c6)
  );

  // ratio and limits share the 100 MHz unit, so a plain compare works
  for (genvar b = 0; b < NUM_BANDS; b++) begin : g_band
    assign band_hit[b] = freq_ratio >=
      filter_q[b*BAND_W +: BAND_W];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filter_q <= '0;
    end else if (wr_now && hit_filter) begin
      filter_q <= hwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // general counters
  for (genvar i = 0; i < NUM_CTR; i++) begin : g_ctr
    pupc_lane_if lif ();
    wire [6:0] code = ctl_q[i][EVSEL_MSB-1:0];
    wire [1:0] occ_sel = ctl_q[i][OCCSEL_MSB:OCCSEL_LSB];
    wire is_band = (code >= EV_BAND0) && (code <= EV_BAND3);
    wire [1:0] band_idx = 2'(code - EV_BAND0);
    wire hit_ctl = wr_now && in_ctl && (ctl_idx == 2'(i));
    wire hit_ctr = wr_now && in_ctr && (ctr_idx == 2'(i));

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        ctl_q[i] <= '0;
      end else if (hit_ctl) begin
        ctl_q[i] <= hwdata & CTL_WMASK;
      end
    end

    // code 0x03 is the voltage-change line of the event bus
    assign lif.ev_bit = (code == EV_CLOCKTICKS) ? 1'b1
      : is_band ? band_hit[band_idx] : direct_events[code];
    assign lif.occ = (occ_sel == OCC_SEL_C0) ? occ_c0
      : (occ_sel == OCC_SEL_C3) ? occ_c3
      : (occ_sel == OCC_SEL_C6) ? occ_c6 : '0;
    assign lif.ctl = ctl_q[i];
    assign lif.run = ~global_freeze;
    assign lif.wr_lo = hit_ctr & ~ctr_hi;
    assign lif.wr_hi = hit_ctr & ctr_hi;
    // reset bit is write-only and acts as a one-shot clear
    assign lif.clr = hit_ctl & hwdata[RST_BIT];
    assign lif.wdata = hwdata;
    assign ctr_val[i] = lif.count;
    assign carry_vec[i] = lif.carry & ctl_q[i][OVEN_BIT];

    pupc_lane u_lane (
      .hclk(hclk),
      .hresetn(hresetn),
      .lif(lif)
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // overflow status: write one to clear, a new overflow wins
  always_comb begin
    status_d = status_q;
    if (wr_now && hit_status) begin
      status_d = status_q & ~hwdata[NUM_CTR-1:0];
    end
    status_d = status_d | carry_vec;
  end

  // one message per overflow cycle, naming every overflow-enabled counter that wrapped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= '0;
      ovf_valid_q <= 1'b0;
      ovf_mask_q <= '0;
    end else begin
      status_q <= status_d;
      ovf_valid_q <= |carry_vec;
      ovf_mask_q <= carry_vec;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // C-state residency counters, outside freeze and counter controls
  always_comb begin
    c3_d = c3_q;
    c6_d = c6_q;
    if (wr_now && hit_c3_lo) begin
      c3_d[DATA_W-1:0] = hwdata;
    end else if (wr_now && hit_c3_hi) begin
      c3_d[CST_W-1:DATA_W] = hwdata;
    end else if (any_c3) begin
      c3_d = c3_q + CST_W'(1);
    end
    if (wr_now && hit_c6_lo) begin
      c6_d[DATA_W-1:0] = hwdata;
    end else if (wr_now && hit_c6_hi) begin
      c6_d[CST_W-1:DATA_W] = hwdata;
    end else if (any_c6) begin
      c6_d = c6_q + CST_W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      c3_q <= '0;
      c6_q <= '0;
    end else begin
      c3_q <= c3_d;
      c6_q <= c6_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs; hresp is a flop held at OKAY
  logic hresp_q;
  logic [7:0] unit_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_q <= HRESP_OKAY;
      unit_q <= '0;
    end else begin
      hresp_q <= HRESP_OKAY;
      unit_q <= UNIT_ID;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign ovf_msg_valid = ovf_valid_q;
  assign ovf_msg_unit = unit_q;
  assign ovf_msg_mask = ovf_mask_q;
endmodule : pupc_top

// File: include/pupc_pkg.sv
package pupc_pkg;
  ////////////////////////////////////////////////////////////////////////
  // widths
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int CTR_W = 48;
  localparam int CST_W = 64;
  localparam int OCC_W = 4;
  localparam int INC_W = 5;
  localparam int NUM_CTR = 4;
  localparam int NUM_BANDS = 4;
  localparam int BAND_W = 8;
  localparam int NUM_EV = 128;
  // band limits are frequency ratios, one unit per step
  localparam int FREQ_STEP_MHZ = 100;
  ////////////////////////////////////////////////////////////////////////
  // register byte offsets (64-bit registers take a low and a high word)
  localparam logic [ADDR_W-1:0] OFS_CTR_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTL_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_FILTER = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_FILTER_HI = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_C6_LO = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_C6_HI = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_C3_LO = 8'h48;
  localparam logic [ADDR_W-1:0] OFS_C3_HI = 8'h4c;
  ////////////////////////////////////////////////////////////////////////
  // control word fields
  localparam int EVSEL_MSB = 7;
  localparam int OCC_FLAG_BIT = 7;
  localparam int OCCSEL_LSB = 14;
  localparam int OCCSEL_MSB = 15;
  localparam int RST_BIT = 17;
  localparam int EDGE_BIT = 18;
  localparam int OVEN_BIT = 20;
  localparam int EN_BIT = 22;
  localparam int THR_LSB = 24;
  localparam int THR_MSB = 28;
  localparam int INV_BIT = 30;
  localparam int OCC_EDGE_BIT = 31;
  localparam logic [DATA_W-1:0] CTL_WMASK = 32'hdf74_c0ff;
  localparam logic [1:0] OCC_SEL_C0 = 2'h1;
  localparam logic [1:0] OCC_SEL_C3 = 2'h2;
  localparam logic [1:0] OCC_SEL_C6 = 2'h3;
  ////////////////////////////////////////////////////////////////////////
  // event codes; clockticks and bands handled inside, 0x03 taken from the event bus
  localparam logic [6:0] EV_CLOCKTICKS = 7'h00;
  localparam logic [6:0] EV_VOLT_CHANGE = 7'h03;
  localparam logic [6:0] EV_BAND0 = 7'h0b;
  localparam logic [6:0] EV_BAND3 = 7'h0e;
  ////////////////////////////////////////////////////////////////////////
  // bus
  localparam logic HRESP_OKAY = 1'b0;
endpackage : pupc_pkg

// File: include/pupc_lane_if.sv
`timescale 1ns/100ps
interface pupc_lane_if;
  import pupc_pkg::*;
  logic [DATA_W-1:0] ctl;
  logic ev_bit;
  logic [OCC_W-1:0] occ;
  logic run;
  logic wr_lo;
  logic wr_hi;
  logic clr;
  logic [DATA_W-1:0] wdata;
  logic [CTR_W-1:0] count;
  logic carry;
  modport hub (output ctl, ev_bit, occ, run, wr_lo, wr_hi, clr, wdata,
    input count, carry);
  modport lane (input ctl, ev_bit, occ, run, wr_lo, wr_hi, clr, wdata,
    output count, carry);
endinterface : pupc_lane_if

// File: logic/pupc_occupancy.sv
`timescale 1ns/100ps
module pupc_occupancy
  import pupc_pkg::*;
#(
  parameter int NUM_CORES = 15
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [NUM_CORES-1:0] core_in_c0,
  input wire logic [NUM_CORES-1:0] core_in_c3,
  input wire logic [NUM_CORES-1:0] core_in_c6,
  output logic [OCC_W-1:0] occ_c0_q,
  output logic [OCC_W-1:0] occ_c3_q,
  output logic [OCC_W-1:0] occ_c6_q,
  output logic any_c3_q,
  output logic any_c6_q
);
  // a 4-bit count cannot hold more cores than this
  if (NUM_CORES > (1 << OCC_W) - 1) begin : g_chk
    $error("pupc_occupancy: too many cores for the occupancy width");
  end

  function automatic logic [OCC_W-1:0] pupc_popcount(
    input logic [NUM_CORES-1:0] v);
    logic [OCC_W-1:0] n;
    n = '0;
    for (int i = 0; i < NUM_CORES; i++) begin
      n = n + OCC_W'(v[i]);
    end
    return n;
  endfunction : pupc_popcount

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      occ_c0_q <= '0;
      occ_c3_q <= '0;
      occ_c6_q <= '0;
      any_c3_q <= 1'b0;
      any_c6_q <= 1'b0;
    end else begin
      occ_c0_q <= pupc_popcount(core_in_c0);
      occ_c3_q <= pupc_popcount(core_in_c3);
      occ_c6_q <= pupc_popcount(core_in_c6);
      any_c3_q <= |core_in_c3;
      any_c6_q <= |core_in_c6;
    end
  end
endmodule : pupc_occupancy

// File: logic/pupc_lane.sv
`timescale 1ns/100ps
module pupc_lane
  import pupc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  pupc_lane_if.lane lif
);
  logic [CTR_W-1:0] count_q;
  logic [CTR_W-1:0] count_d;
  logic qual_q;
  wire occ_mode = lif.ctl[OCC_FLAG_BIT];
  wire [INC_W-1:0] raw = occ_mode ? {1'b0, lif.occ}
                                  : {{(INC_W-1){1'b0}}, lif.ev_bit};
  wire [INC_W-1:0] thr = lif.ctl[THR_MSB:THR_LSB];
  // invert only applies to occupancy selections
  wire inv = occ_mode & lif.ctl[INV_BIT];
  wire qual = inv ? (raw < thr) : (raw >= thr);
  wire edge_on = lif.ctl[EDGE_BIT] | lif.ctl[OCC_EDGE_BIT];
  // threshold zero accumulates the raw increment
  wire [INC_W-1:0] step = (thr == '0) ? raw
    : edge_on ? INC_W'(qual & ~qual_q)
    : INC_W'(qual);
  wire counting = lif.run & lif.ctl[EN_BIT];
  wire [CTR_W:0] sum = {1'b0, count_q} + {{(CTR_W+1-INC_W){1'b0}}, step};
  wire sw_touch = lif.clr | lif.wr_lo | lif.wr_hi;

  ////////////////////////////////////////////////////////////////////////
  // software access beats an increment in the same cycle
  always_comb begin
    count_d = count_q;
    if (lif.clr) begin
      count_d = '0;
    end else if (lif.wr_lo) begin
      count_d = {count_q[CTR_W-1:DATA_W], lif.wdata};
    end else if (lif.wr_hi) begin
      count_d = {lif.wdata[CTR_W-DATA_W-1:0], count_q[DATA_W-1:0]};
    end else if (counting) begin
      count_d = sum[CTR_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= '0;
      qual_q <= 1'b0;
    end else begin
      count_q <= count_d;
      qual_q <= qual;
    end
  end

  assign lif.count = count_q;
  assign lif.carry = counting & ~sw_touch & sum[CTR_W];
endmodule : pupc_lane

// File: verif/pupc_top_asserts.sv
`timescale 1ns/100ps
module pupc_top_asserts
  import pupc_pkg::*;
#(
  parameter int NUM_CORES = 15,
  parameter logic [7:0] UNIT_ID = 8'h5a
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [DATA_W-1:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic ovf_msg_valid,
  input wire logic [7:0] ovf_msg_unit,
  input wire logic [NUM_CTR-1:0] ovf_msg_mask
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////
  wire go = hsel && hready && htrans[1];
  wire rd_go = go && !hwrite && haddr[31:8] == 24'h0;
  wire wr_go = go && hwrite;
  property p_rd_wait;
    go && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("bad read wait");
  property p_wr_nowait;
    wr_go |=> hreadyout;
  endproperty
  a_wr_nowait: assert property (p_wr_nowait)
    else $error("write stall");
  property p_okay;
    hresp == HRESP_OKAY;
  endproperty
  a_okay: assert property (p_okay) else $error("resp not okay");
  property p_hi_rsv;
    rd_go && haddr[7:5] == 3'h0 && haddr[2] |-> ##2 hrdata[31:16] == 16'h0;
  endproperty
  a_hi_rsv: assert property (p_hi_rsv)
    else $error("count hi bits set");
  property p_filt_hi;
    rd_go && haddr[7:0] == OFS_FILTER_HI |-> ##2 hrdata == 32'h0;
  endproperty
  a_filt_hi: assert property (p_filt_hi)
    else $error("filter hi set");
  property p_ctl_rsv;
    rd_go && haddr[7:4] == 4'h2 |-> ##2 (hrdata & ~CTL_WMASK) == 32'h0;
  endproperty
  a_ctl_rsv: assert property (p_ctl_rsv) else $error("ctl rsv set");
  // one pulse per overflow, never a level
  property p_pulse;
    ovf_msg_valid |=> !ovf_msg_valid;
  endproperty
  a_pulse: assert property (p_pulse) else $error("msg too long");
  property p_unit;
    $past(hresetn) |-> ovf_msg_unit == UNIT_ID;
  endproperty
  a_unit: assert property (p_unit) else $error("bad unit tag");
  property p_mask;
    ovf_msg_valid |-> ovf_msg_mask != 4'h0;
  endproperty
  a_mask: assert property (p_mask) else $error("empty msg mask");
  c_read: cover property (rd_go);
  c_write: cover property (wr_go);
  c_msg: cover property (ovf_msg_valid);
endmodule : pupc_top_asserts

bind pupc_top pupc_top_asserts #(.NUM_CORES(NUM_CORES),
  .UNIT_ID(UNIT_ID)) chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .ovf_msg_valid(ovf_msg_valid),
  .ovf_msg_unit(ovf_msg_unit), .ovf_msg_mask(ovf_msg_mask));

// File: verif/pupc_gmon_model.sv
`timescale 1ns/100ps
// global monitor: freezes counting a few cycles after an overflow message
module pupc_gmon_model #(
  parameter int FREEZE_DLY = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ovf_msg_valid,
  input wire logic [7:0] ovf_msg_unit,
  input wire logic [3:0] ovf_msg_mask,
  input wire logic thaw,
  output logic global_freeze,
  output logic [7:0] seen_unit,
  output logic [3:0] seen_mask,
  output logic [7:0] msg_count
);
  logic [3:0] dly_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      global_freeze <= 1'b0;
      dly_q <= 4'h0;
      seen_unit <= 8'h0;
      seen_mask <= 4'h0;
      msg_count <= 8'h0;
    end else begin
      if (ovf_msg_valid) begin
        seen_unit <= ovf_msg_unit;
        seen_mask <= ovf_msg_mask;
        msg_count <= msg_count + 8'h1;
        dly_q <= 4'(FREEZE_DLY);
      end else if (dly_q != 4'h0) begin
        dly_q <= dly_q - 4'h1;
      end
      // slow answer on purpose, so the counter wraps before freezing
      if (dly_q == 4'h1) begin
        global_freeze <= 1'b1;
      end else if (thaw) begin
        global_freeze <= 1'b0;
      end
    end
  end
endmodule : pupc_gmon_model

// File: verif/testbench.sv
`timescale 1ns/100ps
module testbench;
  import pupc_pkg::*;
  localparam logic [7:0] UNIT_ID = 8'h3c; // arbitrary value
  localparam logic [31:0] CLR = 32'h0002_0000;
  localparam logic [31:0] TBL [8][3] = '{
    '{32'h04, 32'hffff_ffff, 32'h0000_ffff}, '{32'h18, 32'h89ab_cdef,
    32'h89ab_cdef}, '{32'h30, 32'h1234_5678, 32'h1234_5678},
    '{32'h34, 32'hffff_ffff, 32'h0}, '{32'h44, 32'hdead_beef, 32'hdead_beef},
    '{32'h4c, 32'h0bad_cafe, 32'h0bad_cafe},
    '{32'h24, 32'hffbf_ffff, 32'hdf34_c0ff}, '{32'h80, 32'hffff_ffff, 32'h0}};
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ev3 = 0, thaw = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd, v1;
  logic [1:0] htrans = 0;
  logic [14:0] c0 = 0, c3 = 0, c6 = 0;
  logic [7:0] freq = 0, ovf_u, seen_u, msgs;
  logic [31:0] hrdata;
  logic hreadyout, hresp, ovf_v, freeze;
  logic [3:0] ovf_m, seen_m;
  int miscompares = 0, total_checks = 0, i, k;
  always #4 hclk = ~hclk;
  ////////////////////////////////////////////////////////////////////////
  pupc_top #(.UNIT_ID(UNIT_ID)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .core_in_c0(c0), .core_in_c3(c3),
    .core_in_c6(c6), .freq_ratio(freq), .direct_events({124'h0, ev3, 3'h0}),
    .global_freeze(freeze), .ovf_msg_valid(ovf_v), .ovf_msg_unit(ovf_u),
    .ovf_msg_mask(ovf_m));
  pupc_gmon_model gmon (.hclk(hclk), .hresetn(hresetn), .ovf_msg_valid(ovf_v),
    .ovf_msg_unit(ovf_u), .ovf_msg_mask(ovf_m), .thaw(thaw),
    .global_freeze(freeze), .seen_unit(seen_u), .seen_mask(seen_m),
    .msg_count(msgs));
  ////////////////////////////////////////////////////////////////////////
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task wait_rdy;
    int n;
    for (n = 0; n < 20; n++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    if (n == 20) begin
      miscompares++;
      $display("wrong value at %0t: bus hang", $time);
      wrap_up;
    end
  endtask : wait_rdy
  // read data taken at the edge that ends the data phase
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask : xfer
  task rdc(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc
  task cfg(input logic [31:0] a, input logic [31:0] v);
    xfer(1'b1, a, v | CLR);
  endtask : cfg
  task hold(input logic [14:0] a0, a3, a6, input logic e,
    input logic [7:0] f, input int n);
    @(posedge hclk);
    c0 <= a0;
    c3 <= a3;
    c6 <= a6;
    ev3 <= e;
    freq <= f;
    repeat (n - 1) @(posedge hclk);
  endtask : hold
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (i = 0; i < 8; i++) begin
      rdc(TBL[i][0], 32'h0);
      xfer(1'b1, TBL[i][0], TBL[i][1]);
      rdc(TBL[i][0], TBL[i][2]);
    end
    cfg(32'h24, 32'h0);
    $display("table done");
    cfg(32'h20, 32'h0040_0003);
    cfg(32'h24, 32'h0144_0003);
    hold(0, 0, 0, 1, 0, 3);
    hold(0, 0, 0, 0, 0, 2);
    hold(0, 0, 0, 1, 0, 4);
    hold(0, 0, 0, 0, 0, 4);
    rdc(32'h00, 32'h7);
    rdc(32'h08, 32'h2);
    $display("direct done");
    cfg(32'h28, 32'h0040_4080);
    for (k = 0; k < 2; k++) begin
      cfg(32'h2c, k ? 32'h8540_4080 : 32'h0540_4080);
      hold(15'h003f, 0, 0, 0, 0, 6);
      hold(15'h0003, 0, 0, 0, 0, 3);
      hold(15'h001f, 0, 0, 0, 0, 4);
      hold(0, 0, 0, 0, 0, 4);
      rdc(32'h18, k ? 32'h2 : 32'ha);
    end
    rdc(32'h10, 32'h7c);
    $display("occupancy done");
    // first write arms the qual history; the second clears its false edge
    cfg(32'h2c, 32'h4244_8080);
    for (i = 0; i < 4; i++) xfer(1'b1, 32'h40 + 4 * i, 32'h0);
    cfg(32'h28, 32'h0240_8080);
    cfg(32'h20, 32'h0040_c080);
    cfg(32'h2c, 32'h4244_8080);
    hold(0, 15'h0007, 15'h0003, 0, 0, 4);
    hold(0, 15'h0001, 0, 0, 0, 2);
    hold(0, 0, 0, 0, 0, 4);
    rdc(32'h10, 32'h4);
    rdc(32'h00, 32'h8);
    rdc(32'h48, 32'h6);
    rdc(32'h40, 32'h4);
    rdc(32'h18, 32'h1);
    $display("c-state done");
    xfer(1'b1, 32'h30, 32'h2820_1410);
    for (i = 0; i < 4; i++) begin
      cfg(32'h20 + 4 * i, 32'h0040_000b + i);
    end
    hold(0, 0, 0, 0, 8'h20, 5);
    hold(0, 0, 0, 0, 8'h28, 2);
    hold(0, 0, 0, 0, 0, 4);
    for (i = 0; i < 4; i++) begin
      rdc(32'h00 + 8 * i, i == 3 ? 2 : 7);
    end
    $display("band done");
    cfg(32'h24, 32'h0);
    xfer(1'b1, 32'h08, 32'hffff_fffb);
    xfer(1'b1, 32'h0c, 32'h0000_ffff);
    xfer(1'b1, 32'h24, 32'h0050_0000);
    repeat (20) @(posedge hclk);
    chk({24'h0, msgs}, 32'h1);
    chk({28'h0, seen_m}, 32'h2);
    chk({24'h0, seen_u}, {24'h0, UNIT_ID});
    rdc(32'h38, 32'h2);
    rdc(32'h0c, 32'h0);
    xfer(1'b0, 32'h08, 32'h0);
    v1 = rd;
    // wrap to zero, then one count per cycle until the freeze lands: the message cycle plus the model's delay
    chk(v1, 32'h4);
    rdc(32'h08, v1);
    xfer(1'b1, 32'h40, 32'h0);
    hold(0, 0, 15'h0100, 0, 0, 3);
    hold(0, 0, 0, 0, 0, 4);
    rdc(32'h40, 32'h3);
    xfer(1'b1, 32'h38, 32'h2);
    rdc(32'h38, 32'h0);
    thaw <= 1'b1;
    $display("overflow done");
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(32'h24, 32'h0);
    rdc(32'h40, 32'h0);
    $display("reset done");
    wrap_up;
  end
endmodule : testbench
